/* src/prog_port_pkg.sv */
// Constants, codes and state encoding for the parallel flash programming port
package prog_port_pkg;

  // Port widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 32;
  localparam int MODE_W = 4;
  localparam int FOP_W = 3;
  localparam int BYTE_W = 8;

  // Transfer type field codes
  localparam logic [MODE_W-1:0] MODE_CMD = 4'h0;
  localparam logic [MODE_W-1:0] MODE_ADDR_FIRST = 4'h1;
  localparam logic [MODE_W-1:0] MODE_ADDR_LAST = 4'h4;
  localparam logic [MODE_W-1:0] MODE_DATA = 4'h5;

  // Command codes
  localparam logic [DATA_W-1:0] CMD_READ = 16'h0011;
  localparam logic [DATA_W-1:0] CMD_WRITE_PAGE = 16'h0012;
  localparam logic [DATA_W-1:0] CMD_WRITE_PAGE_LOCK = 16'h0022;
  localparam logic [DATA_W-1:0] CMD_ERASE_THEN_WRITE = 16'h0032;
  localparam logic [DATA_W-1:0] CMD_ERASE_WRITE_LOCK = 16'h0042;
  localparam logic [DATA_W-1:0] CMD_ERASE_ALL = 16'h0013;
  localparam logic [DATA_W-1:0] CMD_CLEAR_LOCK = 16'h0024;
  localparam logic [DATA_W-1:0] CMD_NONE = 16'h0000;
  localparam logic [DATA_W-1:0] ERASE_ALL_ARG = 16'h0000;

  // Operations requested from the flash macro
  localparam logic [FOP_W-1:0] FOP_NONE = 3'h0;
  localparam logic [FOP_W-1:0] FOP_ERASE_PAGE = 3'h1;
  localparam logic [FOP_W-1:0] FOP_PROGRAM_PAGE = 3'h2;
  localparam logic [FOP_W-1:0] FOP_SET_LOCK = 3'h3;
  localparam logic [FOP_W-1:0] FOP_ERASE_ALL = 3'h4;
  localparam logic [FOP_W-1:0] FOP_CLEAR_LOCK = 3'h5;

  // Geometry and reset values
  localparam int PAGE_BYTES_DEF = 128;
  localparam int ADDR_STEP = 2;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

  // Timing: main clock counts as present above 32 kHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int MAIN_CLK_MAX_PERIOD_NS = 31250;
  localparam int DETECT_CYCLES_DEF = MAIN_CLK_MAX_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DETECT_MIN_EDGES = 2;
  localparam int READ_LATENCY_DEF = 1;

  // Handshake and flush sequencer states
  typedef enum logic [14:0] {
    ST_DETECT       = 15'h0001,
    ST_IDLE         = 15'h0002,
    ST_DECODE       = 15'h0004,
    ST_ERASE        = 15'h0008,
    ST_STREAM       = 15'h0010,
    ST_PROG         = 15'h0020,
    ST_LOCK         = 15'h0040,
    ST_ERASE_ALL    = 15'h0080,
    ST_CLEAR_LOCK   = 15'h0100,
    ST_READ_WAIT_OE = 15'h0200,
    ST_READ_FETCH   = 15'h0400,
    ST_READ_DRIVE   = 15'h0800,
    ST_READ_HOLD    = 15'h1000,
    ST_READ_RELEASE = 15'h2000,
    ST_WAIT_HIGH    = 15'h4000
  } state_type;

endpackage

/* src/parallel_flash_programming_port.sv */
// Parallel handshaked flash programming port with page load buffer
`timescale 1ns/1ps

module parallel_flash_programming_port
  import prog_port_pkg::*;
#(
  parameter int PAGE_BYTES = PAGE_BYTES_DEF,
  parameter int DETECT_CYCLES = DETECT_CYCLES_DEF,
  parameter int READ_LATENCY = READ_LATENCY_DEF
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic main_clock_input_i,
  input wire logic prog_strobe_pin_n_i,
  input wire logic prog_read_req_pin_n_i,
  input wire logic [MODE_W-1:0] transfer_type_field_i,
  input wire logic [DATA_W-1:0] prog_data_bus_i,
  output logic [DATA_W-1:0] prog_data_bus_o,
  output logic prog_data_bus_oe_n_o,
  output logic prog_ready_pin_o,
  output logic prog_data_valid_pin_n_o,
  output logic main_clock_select_o,
  output logic flash_cmd_valid_o,
  output logic [FOP_W-1:0] flash_cmd_op_o,
  output logic [ADDR_W-1:0] flash_cmd_addr_o,
  output logic [DATA_W-1:0] flash_cmd_mask_o,
  input wire logic flash_cmd_done_i,
  input wire logic flash_locked_any_i,
  output logic flash_wdata_valid_o,
  output logic [DATA_W-1:0] flash_wdata_o,
  input wire logic flash_wdata_ready_i,
  output logic [ADDR_W-1:0] flash_raddr_o,
  input wire logic [DATA_W-1:0] flash_rdata_i
);

  localparam int PAGE_WORDS = PAGE_BYTES / ADDR_STEP;
  localparam int OFFSET_W = $clog2(PAGE_BYTES);
  localparam int WIDX_W = $clog2(PAGE_WORDS);
  localparam int PAGE_W = ADDR_W - OFFSET_W;
  localparam int CNT_W = WIDX_W + 1;
  localparam int DET_W = $clog2(DETECT_CYCLES + 1);
  localparam int LAT_W = $clog2(READ_LATENCY + 1);

  // Page number and word index of a byte address
  function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = a[ADDR_W-1:OFFSET_W];
  endfunction

  function automatic logic [WIDX_W-1:0] word_of(input logic [ADDR_W-1:0] a);
    word_of = a[OFFSET_W-1:1];
  endfunction

  state_type state_reg, state_next;
  logic [MODE_W-1:0] mode_reg;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] cmd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [PAGE_W-1:0] buf_page_reg;
  logic dirty_reg;
  logic [DATA_W-1:0] buf_mem [PAGE_WORDS];
  logic [CNT_W-1:0] stream_cnt_reg;
  logic [LAT_W-1:0] lat_reg;
  logic [DET_W-1:0] det_cnt_reg;
  logic [1:0] edge_cnt_reg;
  logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic head_valid_reg, tail_valid_reg;
  logic [DATA_W-1:0] head_data_reg, tail_data_reg;

  // Command and mode decode
  wire erase_variant = (cmd_reg == CMD_ERASE_THEN_WRITE) || (cmd_reg == CMD_ERASE_WRITE_LOCK);
  wire lock_variant = (cmd_reg == CMD_WRITE_PAGE_LOCK) || (cmd_reg == CMD_ERASE_WRITE_LOCK);
  wire is_write_cmd = (cmd_reg == CMD_WRITE_PAGE) || erase_variant || lock_variant;
  wire dec_cmd = (mode_reg == MODE_CMD);
  wire dec_addr = (mode_reg >= MODE_ADDR_FIRST) && (mode_reg <= MODE_ADDR_LAST);
  wire dec_data = (mode_reg == MODE_DATA);
  wire [1:0] addr_byte_sel = 2'(mode_reg - MODE_ADDR_FIRST);
  wire in_decode = (state_reg == ST_DECODE);
  wire page_miss = dirty_reg && (page_of(addr_reg) != buf_page_reg);
  wire flush_start = in_decode && dirty_reg && (dec_cmd || (dec_data && is_write_cmd && page_miss));
  wire store_word = in_decode && !flush_start && dec_data && is_write_cmd;
  wire do_read = in_decode && dec_data && (cmd_reg == CMD_READ);
  wire ea_request = in_decode && dec_data && (cmd_reg == CMD_ERASE_ALL) && (data_reg == ERASE_ALL_ARG);
  wire ea_go = ea_request && !flash_locked_any_i;
  wire clr_go = in_decode && dec_data && (cmd_reg == CMD_CLEAR_LOCK);
  wire lat_done = (lat_reg == LAT_W'(READ_LATENCY));
  wire read_capture = (state_reg == ST_READ_FETCH) && lat_done;
  wire flush_done = flash_cmd_done_i && (((state_reg == ST_PROG) && !lock_variant) || (state_reg == ST_LOCK));
  wire det_end = (det_cnt_reg == DET_W'(DETECT_CYCLES - 1));
  wire main_clk_rise = clk_s2_reg && !clk_s3_reg;

  // Two-entry buffer toward the flash macro; a stalled macro stops the stream
  wire fifo_push_ready = !tail_valid_reg;
  wire stream_all = (stream_cnt_reg == CNT_W'(PAGE_WORDS));
  wire fifo_push = (state_reg == ST_STREAM) && !stream_all && fifo_push_ready;
  wire fifo_pop = head_valid_reg && flash_wdata_ready_i;
  wire stream_done = stream_all && !head_valid_reg && !tail_valid_reg;
  wire [DATA_W-1:0] push_word = buf_mem[stream_cnt_reg[WIDX_W-1:0]];
  wire head_load = !head_valid_reg || fifo_pop;
  wire head_valid_next = head_load ? (tail_valid_reg || fifo_push) : 1'b1;
  wire [DATA_W-1:0] head_data_next = !head_load ? head_data_reg : (tail_valid_reg ? tail_data_reg : push_word);
  wire tail_valid_next = tail_valid_reg ? !fifo_pop : (fifo_push && head_valid_reg && !fifo_pop);

  // Next state of the handshake and flush sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_DETECT: if (det_end) state_next = ST_IDLE;
      ST_IDLE: if (!prog_strobe_pin_n_i) state_next = ST_DECODE;
      ST_DECODE: begin
        if (flush_start) state_next = erase_variant ? ST_ERASE : ST_STREAM;
        else if (do_read) state_next = ST_READ_WAIT_OE;
        else if (ea_go) state_next = ST_ERASE_ALL;
        else if (clr_go) state_next = ST_CLEAR_LOCK;
        else state_next = ST_WAIT_HIGH;
      end
      ST_ERASE: if (flash_cmd_done_i) state_next = ST_STREAM;
      ST_STREAM: if (stream_done) state_next = ST_PROG;
      ST_PROG: if (flash_cmd_done_i) state_next = lock_variant ? ST_LOCK : ST_DECODE;
      ST_LOCK: if (flash_cmd_done_i) state_next = ST_DECODE;
      ST_ERASE_ALL: if (flash_cmd_done_i) state_next = ST_WAIT_HIGH;
      ST_CLEAR_LOCK: if (flash_cmd_done_i) state_next = ST_WAIT_HIGH;
      ST_READ_WAIT_OE: if (!prog_read_req_pin_n_i) state_next = ST_READ_FETCH;
      ST_READ_FETCH: if (lat_done) state_next = ST_READ_DRIVE;
      ST_READ_DRIVE: state_next = ST_READ_HOLD;
      ST_READ_HOLD: if (prog_read_req_pin_n_i) state_next = ST_READ_RELEASE;
      ST_READ_RELEASE: state_next = ST_WAIT_HIGH;
      ST_WAIT_HIGH: if (prog_strobe_pin_n_i) state_next = ST_IDLE;
      default: state_next = ST_DETECT;
    endcase
  end

  // Pin and macro outputs follow the next state so they stay registered
  wire ready_next = (state_next == ST_IDLE);
  wire drive_next = (state_next == ST_READ_DRIVE) || (state_next == ST_READ_HOLD);
  wire valid_next = (state_next == ST_READ_HOLD) || (state_next == ST_READ_RELEASE);
  wire [FOP_W-1:0] op_next = (state_next == ST_ERASE) ? FOP_ERASE_PAGE :
                             (state_next == ST_PROG) ? FOP_PROGRAM_PAGE :
                             (state_next == ST_LOCK) ? FOP_SET_LOCK :
                             (state_next == ST_ERASE_ALL) ? FOP_ERASE_ALL :
                             (state_next == ST_CLEAR_LOCK) ? FOP_CLEAR_LOCK : FOP_NONE;

  // Sequencer and pin registers
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_reg <= ST_DETECT;
      prog_ready_pin_o <= 1'b0;
      prog_data_bus_oe_n_o <= 1'b1;
      prog_data_valid_pin_n_o <= 1'b1;
      flash_cmd_valid_o <= 1'b0;
      flash_cmd_op_o <= FOP_NONE;
    end else begin
      state_reg <= state_next;
      prog_ready_pin_o <= ready_next;
      prog_data_bus_oe_n_o <= !drive_next;
      prog_data_valid_pin_n_o <= !valid_next;
      flash_cmd_valid_o <= (op_next != FOP_NONE);
      flash_cmd_op_o <= op_next;
    end
  end

  // Capture of mode and data on strobe low
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      mode_reg <= MODE_CMD;
      data_reg <= CMD_NONE;
    end else if ((state_reg == ST_IDLE) && !prog_strobe_pin_n_i) begin
      mode_reg <= transfer_type_field_i;
      data_reg <= prog_data_bus_i;
    end
  end

  // Command register is only replaced once the buffer is clean
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cmd_reg <= CMD_NONE;
    end else if (in_decode && dec_cmd && !dirty_reg) begin
      cmd_reg <= data_reg;
    end
  end

  // Address assembly and auto-increment
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      addr_reg <= '0;
    end else if (in_decode && dec_addr) begin
      addr_reg[addr_byte_sel*BYTE_W +: BYTE_W] <= data_reg[BYTE_W-1:0];
    end else if (store_word || read_capture) begin
      addr_reg <= addr_reg + ADDR_W'(ADDR_STEP);
    end
  end

  // Load buffer; unwritten words keep the erased value
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || flush_done) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        buf_mem[i] <= ERASED_WORD;
      end
    end else if (store_word) begin
      buf_mem[word_of(addr_reg)] <= data_reg;
    end
  end

  // Buffer ownership: dirty flag and the page it belongs to
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      dirty_reg <= 1'b0;
      buf_page_reg <= '0;
    end else if (store_word) begin
      dirty_reg <= 1'b1;
      buf_page_reg <= page_of(addr_reg);
    end else if (flush_done) begin
      dirty_reg <= 1'b0;
    end
  end

  // Macro command address and mask
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      flash_cmd_addr_o <= '0;
      flash_cmd_mask_o <= '0;
    end else if (in_decode) begin
      flash_cmd_addr_o <= {buf_page_reg, OFFSET_W'(0)};
      flash_cmd_mask_o <= data_reg;
    end
  end

  // Stream counter over the page during a flush
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || state_reg != ST_STREAM) begin
      stream_cnt_reg <= '0;
    end else if (fifo_push) begin
      stream_cnt_reg <= stream_cnt_reg + CNT_W'(1);
    end
  end

  // Two-entry buffer registers; head drives the macro directly
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      head_valid_reg <= 1'b0;
      tail_valid_reg <= 1'b0;
      head_data_reg <= ERASED_WORD;
      tail_data_reg <= ERASED_WORD;
    end else begin
      head_valid_reg <= head_valid_next;
      tail_valid_reg <= tail_valid_next;
      head_data_reg <= head_data_next;
      if (fifo_push && tail_valid_next) tail_data_reg <= push_word;
    end
  end
  assign flash_wdata_valid_o = head_valid_reg;
  assign flash_wdata_o = head_data_reg;

  // Read path: address out, wait the macro latency, hold data on the bus
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      flash_raddr_o <= '0;
      lat_reg <= '0;
      prog_data_bus_o <= '0;
    end else begin
      if ((state_reg == ST_READ_WAIT_OE) && !prog_read_req_pin_n_i) flash_raddr_o <= addr_reg;
      lat_reg <= (state_reg == ST_READ_FETCH) ? lat_reg + LAT_W'(1) : '0;
      if (read_capture) prog_data_bus_o <= flash_rdata_i;
    end
  end

  // Main clock presence: count synchronised edges over one 32 kHz period
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      det_cnt_reg <= '0;
      edge_cnt_reg <= '0;
      main_clock_select_o <= 1'b0;
    end else begin
      clk_s1_reg <= main_clock_input_i;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      if (state_reg == ST_DETECT) begin
        det_cnt_reg <= det_cnt_reg + DET_W'(1);
        if (main_clk_rise && edge_cnt_reg != 2'h3) edge_cnt_reg <= edge_cnt_reg + 2'h1;
        if (det_end) main_clock_select_o <= (edge_cnt_reg >= 2'(DETECT_MIN_EDGES));
      end
    end
  end

  // Checks on the handshake and flush behaviour
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_capture;
    (state_reg == ST_IDLE) && !prog_strobe_pin_n_i;
  endsequence
  property p_ready_drops;
    s_capture |=> !prog_ready_pin_o ##1 !prog_ready_pin_o;
  endproperty
  a_ready_drops: assert property (p_ready_drops) else $error("ready not dropped after capture");
  property p_ready_needs_strobe;
    $rose(prog_ready_pin_o) |-> $past(prog_strobe_pin_n_i);
  endproperty
  a_ready_needs_strobe: assert property (p_ready_needs_strobe) else $error("ready raised with strobe low");
  // The window counter steps once more on its last cycle, so it rests one past the end
  property p_detect_first;
    prog_ready_pin_o |-> (det_cnt_reg == DET_W'(DETECT_CYCLES));
  endproperty
  a_detect_first: assert property (p_detect_first) else $error("ready before clock detection");
  property p_drive_before_valid;
    $fell(prog_data_valid_pin_n_o) |-> !prog_data_bus_oe_n_o && $past(!prog_data_bus_oe_n_o);
  endproperty
  a_drive_before_valid: assert property (p_drive_before_valid) else $error("valid before bus driven");
  property p_release_before_valid_high;
    $rose(prog_data_valid_pin_n_o) |-> prog_data_bus_oe_n_o && $past(prog_data_bus_oe_n_o);
  endproperty
  a_release_before_valid_high: assert property (p_release_before_valid_high) else $error("bus held at valid");
  property p_busy_during_op;
    flash_cmd_valid_o || head_valid_reg |-> !prog_ready_pin_o;
  endproperty
  a_busy_during_op: assert property (p_busy_during_op) else $error("ready high during flash op");
  property p_locked_abort;
    ea_request && flash_locked_any_i |=> ##1 (flash_cmd_op_o != FOP_ERASE_ALL) [*3];
  endproperty
  a_locked_abort: assert property (p_locked_abort) else $error("erase all while locked");
  property p_addr_step;
    store_word |=> addr_reg == $past(addr_reg) + ADDR_W'(ADDR_STEP);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not advanced");
  sequence s_flush_entry;
    ##1 ((state_reg == ST_ERASE) || (state_reg == ST_STREAM)) ##[1:1000] (state_reg == ST_PROG);
  endsequence
  property p_cmd_flushes;
    in_decode && dec_cmd && dirty_reg |-> s_flush_entry;
  endproperty
  a_cmd_flushes: assert property (p_cmd_flushes) else $error("new command did not flush");
  property p_page_miss_flushes;
    in_decode && dec_data && is_write_cmd && page_miss |-> s_flush_entry;
  endproperty
  a_page_miss_flushes: assert property (p_page_miss_flushes) else $error("page change did not flush");
endmodule

/* dv/flash_macro_model.sv */
// Behavioural flash macro facing the port's operation and page-word requests
`timescale 1ns/1ps
module flash_macro_model
  import prog_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic cmd_valid_i,
  input wire logic [FOP_W-1:0] cmd_op_i,
  output logic cmd_done_o,
  input wire logic wdata_valid_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic wdata_ready_o,
  input wire logic [ADDR_W-1:0] raddr_i,
  output logic [DATA_W-1:0] rdata_o
);
  int op_cnt [8] = '{default: 0};
  int word_cnt = 0;
  int busy = 0;
  logic [FOP_W-1:0] last_op = FOP_NONE;
  logic [DATA_W-1:0] wlog [256];
  initial begin
    cmd_done_o = 1'b0;
    wdata_ready_o = 1'b0;
    rdata_o = 16'h0000;
  end
  // Every operation lasts four cycles, then a single done pulse
  always @(posedge clk_i) begin
    cmd_done_o <= 1'b0;
    if (cmd_valid_i && !cmd_done_o) begin
      busy <= busy + 1;
      if (busy == 3) begin
        busy <= 0;
        cmd_done_o <= 1'b1;
        op_cnt[cmd_op_i] <= op_cnt[cmd_op_i] + 1;
        last_op <= cmd_op_i;
      end
    end
  end
  // Ready toggles so the page stream always meets stalls
  always @(posedge clk_i) begin
    wdata_ready_o <= ~wdata_ready_o;
    rdata_o <= raddr_i[16:1] ^ 16'h5a5a;
    if (wdata_valid_i && wdata_ready_o) begin
      wlog[word_cnt % 256] <= wdata_i;
      word_cnt <= word_cnt + 1;
    end
  end
endmodule

/* dv/test_parallel_flash_programming_port.sv */
// Self-checking bench acting as the gang programmer on the port pins
`timescale 1ns/1ps
module test_parallel_flash_programming_port
  import prog_port_pkg::*;
;
  localparam int PB = 16;
  logic clk = 0, resetn = 0, mc = 0, mc_en = 0, stb_n = 1, req_n = 1, locked = 0;
  logic [MODE_W-1:0] mode = '0;
  logic [DATA_W-1:0] din = '0, dout, cmask, wd, rdat;
  logic oe_n, rdy, vld_n, sel, cv, done, wv, wrdy;
  logic [FOP_W-1:0] op;
  logic [ADDR_W-1:0] caddr, raddr;
  int error_cnt = 0, compares = 0;
  parallel_flash_programming_port #(.PAGE_BYTES(PB), .DETECT_CYCLES(20), .READ_LATENCY(1)) dut (
    .core_clk_i(clk), .resetn_i(resetn), .main_clock_input_i(mc),
    .prog_strobe_pin_n_i(stb_n), .prog_read_req_pin_n_i(req_n),
    .transfer_type_field_i(mode), .prog_data_bus_i(din), .prog_data_bus_o(dout),
    .prog_data_bus_oe_n_o(oe_n), .prog_ready_pin_o(rdy), .prog_data_valid_pin_n_o(vld_n),
    .main_clock_select_o(sel), .flash_cmd_valid_o(cv), .flash_cmd_op_o(op),
    .flash_cmd_addr_o(caddr), .flash_cmd_mask_o(cmask), .flash_cmd_done_i(done),
    .flash_locked_any_i(locked), .flash_wdata_valid_o(wv), .flash_wdata_o(wd),
    .flash_wdata_ready_i(wrdy), .flash_raddr_o(raddr), .flash_rdata_i(rdat));
  flash_macro_model m (.clk_i(clk), .cmd_valid_i(cv), .cmd_op_i(op), .cmd_done_o(done),
    .wdata_valid_i(wv), .wdata_i(wd), .wdata_ready_o(wrdy), .raddr_i(raddr), .rdata_o(rdat));
  initial begin
    forever #5 clk = ~clk;
  end
  // Main clock at 25 MHz only while enabled, otherwise held low
  initial begin
    forever #20 mc = mc_en ? ~mc : 1'b0;
  end
  // Ready must stay low while any flash operation runs
  always @(negedge clk) begin
    if (cv === 1'b1) chk("ready while busy", rdy, 0);
  end
  task automatic final_report;
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic pick(int w);
    return w == 0 ? rdy : vld_n;
  endfunction
  // Bounded wait at falling edges; a hang ends the run
  task automatic wait_for(int w, logic v);
    int n;
    n = 0;
    while (pick(w) !== v) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        error_cnt++;
        final_report();
      end
    end
  endtask
  function automatic logic [DATA_W-1:0] fx(logic [ADDR_W-1:0] a);
    return a[16:1] ^ 16'h5a5a;
  endfunction
  task automatic reset(logic e);
    mc_en = e;
    resetn = 0;
    repeat (4) @(negedge clk);
    resetn = 1;
    chk("ready at release", rdy, 0);
    wait_for(0, 1'b1);
  endtask
  task automatic wr(logic [MODE_W-1:0] md, logic [DATA_W-1:0] d);
    wait_for(0, 1'b1);
    mode = md;
    din = d;
    stb_n = 0;
    wait_for(0, 1'b0);
    mode = ~md;
    din = ~d;
    stb_n = 1;
    wait_for(0, 1'b1);
  endtask
  task automatic rd(logic [DATA_W-1:0] exp);
    wait_for(0, 1'b1);
    mode = MODE_DATA;
    stb_n = 0;
    wait_for(0, 1'b0);
    din = ~din;
    @(negedge clk);
    req_n = 0;
    wait_for(1, 1'b0);
    chk("bus direction", oe_n, 0);
    chk("read data", dout, exp);
    req_n = 1;
    wait_for(1, 1'b1);
    chk("bus direction", oe_n, 1);
    chk("ready before strobe", rdy, 0);
    stb_n = 1;
    wait_for(0, 1'b1);
  endtask
  task automatic addr(logic [ADDR_W-1:0] a);
    for (int k = 0; k < 4; k++) wr(4'(MODE_ADDR_FIRST + k), {8'ha5, a[8*k+:8]});
  endtask
  task automatic s_clock;
    reset(0);
    chk("clock select", sel, 0);
    reset(1);
    chk("clock select", sel, 1);
  endtask
  task automatic s_write_read;
    int w;
    w = m.word_cnt;
    wr(MODE_CMD, CMD_WRITE_PAGE);
    addr(32'h0000_0104);
    wr(MODE_DATA, 16'h1234);
    wr(MODE_DATA, 16'h5678);
    wr(4'h6, 16'h0bad);
    chk("early program", m.op_cnt[FOP_PROGRAM_PAGE], 0);
    wr(MODE_CMD, CMD_READ);
    chk("program ops", m.op_cnt[FOP_PROGRAM_PAGE], 1);
    chk("page words", m.word_cnt - w, PB / ADDR_STEP);
    chk("page base", caddr, 32'h0000_0100);
    chk("unwritten word", m.wlog[w], ERASED_WORD);
    chk("word 2", m.wlog[w + 2], 16'h1234);
    chk("word 3", m.wlog[w + 3], 16'h5678);
    chk("idle mode word", m.wlog[w + 4], ERASED_WORD);
    addr(32'h0000_0204);
    rd(fx(32'h0000_0204));
    rd(fx(32'h0000_0206));
    addr(32'h0001_0300);
    rd(fx(32'h0001_0300));
  endtask
  // Data to a second page flushes the first before the new command does
  task automatic s_cross;
    wr(MODE_CMD, CMD_WRITE_PAGE);
    addr(32'h0000_0800);
    wr(MODE_DATA, 16'h0001);
    addr(32'h0000_0800 + PB);
    wr(MODE_DATA, 16'h0002);
    chk("cross page flush", m.op_cnt[FOP_PROGRAM_PAGE], 2);
    wr(MODE_CMD, CMD_READ);
    chk("second flush", m.op_cnt[FOP_PROGRAM_PAGE], 3);
  endtask
  task automatic s_variants;
    logic [DATA_W-1:0] cmds [4] = '{CMD_WRITE_PAGE, CMD_WRITE_PAGE_LOCK, CMD_ERASE_THEN_WRITE, CMD_ERASE_WRITE_LOCK};
    int e, p, l;
    for (int i = 0; i < 4; i++) begin
      e = m.op_cnt[FOP_ERASE_PAGE];
      p = m.op_cnt[FOP_PROGRAM_PAGE];
      l = m.op_cnt[FOP_SET_LOCK];
      wr(MODE_CMD, cmds[i]);
      addr(32'h0000_0400 + 32'(i * PB));
      wr(MODE_DATA, 16'h00a0);
      wr(MODE_CMD, CMD_CLEAR_LOCK);
      chk("erase ops", m.op_cnt[FOP_ERASE_PAGE] - e, i / 2);
      chk("program ops", m.op_cnt[FOP_PROGRAM_PAGE] - p, 1);
      chk("lock ops", m.op_cnt[FOP_SET_LOCK] - l, i % 2);
      chk("last op", m.last_op, (i % 2) ? FOP_SET_LOCK : FOP_PROGRAM_PAGE);
      wr(MODE_DATA, 16'h000f);
    end
    chk("clear lock ops", m.op_cnt[FOP_CLEAR_LOCK], 4);
    chk("clear lock mask", cmask, 16'h000f);
  endtask
  task automatic s_erase_all;
    locked = 1;
    wr(MODE_CMD, CMD_ERASE_ALL);
    wr(MODE_DATA, ERASE_ALL_ARG);
    chk("erase all while locked", m.op_cnt[FOP_ERASE_ALL], 0);
    locked = 0;
    wr(MODE_CMD, CMD_ERASE_ALL);
    wr(MODE_DATA, ERASE_ALL_ARG);
    chk("erase all", m.op_cnt[FOP_ERASE_ALL], 1);
  endtask
  initial begin
    s_clock();
    s_write_read();
    s_cross();
    s_variants();
    s_erase_all();
    final_report();
  end
endmodule
